// ---- common/btpma_pkg.sv ----
// constants for the single-pair long-reach pma/pmd control register bank
// assumes a 16-bit management map reached by device address plus register address
package btpma_pkg;

    // ==========================================================
    // addressing
    localparam logic [4:0] BTPMA_DEV_PMA = 5'h01;
    localparam logic [15:0] BTPMA_OFS_ABILITY = 16'h0012;
    localparam logic [15:0] BTPMA_OFS_CONTROL = 16'h0834;
    localparam logic [15:0] BTPMA_OFS_LR_CONTROL = 16'h08f6;

    // ==========================================================
    // reset and fixed values
    localparam logic [15:0] BTPMA_ABILITY_VALUE = 16'h0004;
    localparam logic [15:0] BTPMA_CONTROL_RESET = 16'h8002;
    localparam logic [15:0] BTPMA_LR_CONTROL_RESET = 16'h0000;
    localparam logic [3:0] BTPMA_TYPE_RESET = 4'h2;

    // ==========================================================
    // field positions of the ability word
    localparam int BTPMA_ABL_MULTIDROP = 3;
    localparam int BTPMA_ABL_LONG_REACH = 2;
    localparam int BTPMA_ABL_GIGABIT = 1;
    localparam int BTPMA_ABL_FAST = 0;

    // ==========================================================
    // field positions of the control word
    localparam int BTPMA_CTL_FIXED_ONE = 15;
    localparam int BTPMA_CTL_MASTER = 14;
    localparam int BTPMA_CTL_TYPE_LSB = 0;
    localparam int BTPMA_CTL_TYPE_MSB = 3;

    // ==========================================================
    // field positions of the long-reach control word
    localparam int BTPMA_LR_SELF_CLEAR = 15;
    localparam int BTPMA_LR_TX_DISABLE = 14;
    localparam int BTPMA_LR_HIGH_AMP = 12;
    localparam int BTPMA_LR_SPARE = 11;
    localparam int BTPMA_LR_EEE = 10;
    localparam int BTPMA_LR_LOOPBACK = 0;

    // ==========================================================
    // phy type codes
    localparam logic [3:0] BTPMA_TYPE_MULTIDROP = 4'h3;
    localparam logic [3:0] BTPMA_TYPE_LONG_REACH = 4'h2;
    localparam logic [3:0] BTPMA_TYPE_FAST = 4'h0;

endpackage

// ---- design/btpma_regs.sv ----
// pma/pmd ability, control and long-reach control registers with mode outputs
// assumes a single-cycle management strobe port and synchronous strap inputs
`timescale 1ns/1ps

// Notes on behaviour
// (R1) The three registers answer only in management device 0x01 at 0x0012, 0x0834 and 0x08f6.
// (R2) The ability register is read only and writes to it change nothing.
// (R3) Ability bit 3 always reads 0, multidrop not supported.
// (R4) Ability bit 2 always reads 1, so the word reads 0x0004.
// (R5) Ability bits 1 and 0 always read 0, gigabit and fast variants not supported.
// (R6) Control bit 14 selects master when 1 and slave when 0, resetting to 1 on port one only.
// (R7) The master select bit applies only with autonegotiation off, else the negotiated role.
// (R8) The type field decodes 0011 multidrop, 0010 long reach, 0000 fast, others reserved.
// (R9) The type field applies only with autonegotiation off and forced link on.
// (R10) Software programs only 0010 into the type field; it resets to 0x2, the word to 0x8002.
// (R11) Long-reach bit 14 at 1 disables transmit output, at 0 enables it.
// (R12) Long-reach bit 12 selects 2.4 V p-p at 1 and 1.0 V p-p at 0, resetting from a strap.
// (R13) The amplitude bit applies only with autonegotiation off, else the negotiated level.
// (R14) Long-reach bit 0 at 1 loops pma transmit data back to receive.
// (R15) Forced-mode fields keep written values while autonegotiation is on.
module btpma_regs
(
    // clock and reset
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    // management access
    input wire logic [4:0] MGMT_DEV_ADDR,
    input wire logic [15:0] MGMT_REG_ADDR,
    input wire logic MGMT_WR,
    input wire logic MGMT_RD,
    input wire logic [15:0] MGMT_WDATA,
    output logic [15:0] MGMT_RDATA,
    output logic MGMT_RVALID,
    // straps
    input wire logic SECOND_PORT,
    input wire logic HIGH_AMP_STRAP,
    // autonegotiation results
    input wire logic AN_ENABLE,
    input wire logic FORCED_LINK_EN,
    input wire logic AN_MASTER,
    input wire logic [3:0] AN_PHY_TYPE,
    input wire logic AN_HIGH_AMP,
    // mode outputs
    output logic MASTER_ROLE,
    output logic TYPE_MULTIDROP,
    output logic TYPE_LONG_REACH,
    output logic TYPE_FAST,
    output logic TYPE_RESERVED,
    output logic TX_OUTPUT_ENABLE,
    output logic HIGH_AMPLITUDE,
    output logic ENERGY_EFFICIENT,
    output logic PMA_LOOPBACK
);
    import btpma_pkg::*;

    // ==========================================================
    // register state
    logic master_role_select;
    logic [3:0] phy_type_select;
    logic transmit_output_disable;
    logic high_amplitude_select;
    logic energy_efficient_enable;
    logic local_pma_loopback_enable;
    logic spare_bit;
    logic self_clear_bit;
    logic strap_pending;
    logic [3:0] eff_type;
    logic [15:0] next_rdata;
    logic sel_pma;
    logic wr_ctl;
    logic wr_lr;

    // decode; anything outside device 0x01 is ignored
    assign sel_pma = (MGMT_DEV_ADDR == BTPMA_DEV_PMA); // [R1]
    assign wr_ctl = MGMT_WR && sel_pma && (MGMT_REG_ADDR == BTPMA_OFS_CONTROL); // [R1]
    assign wr_lr = MGMT_WR && sel_pma && (MGMT_REG_ADDR == BTPMA_OFS_LR_CONTROL); // [R1]

    // straps are caught on the first edge after release, not under reset itself
    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
            strap_pending <= 1'b1;
        else
            strap_pending <= 1'b0;
    end

    // ==========================================================
    // base-t1 control word; writes stick whatever autonegotiation is doing
    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            master_role_select <= BTPMA_CONTROL_RESET[BTPMA_CTL_MASTER];
            phy_type_select <= BTPMA_TYPE_RESET; // [R10]
        end
        else if (wr_ctl)
        begin
            master_role_select <= MGMT_WDATA[BTPMA_CTL_MASTER]; // [R6] [R15]
            phy_type_select <= MGMT_WDATA[BTPMA_CTL_TYPE_MSB:BTPMA_CTL_TYPE_LSB]; // [R15]
        end
        else if (strap_pending)
            master_role_select <= ~SECOND_PORT; // [R6]
    end

    // ==========================================================
    // long-reach control word; a write in the strap cycle wins over the strap
    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            transmit_output_disable <= BTPMA_LR_CONTROL_RESET[BTPMA_LR_TX_DISABLE];
            high_amplitude_select <= BTPMA_LR_CONTROL_RESET[BTPMA_LR_HIGH_AMP];
            energy_efficient_enable <= BTPMA_LR_CONTROL_RESET[BTPMA_LR_EEE];
            local_pma_loopback_enable <= BTPMA_LR_CONTROL_RESET[BTPMA_LR_LOOPBACK];
            spare_bit <= BTPMA_LR_CONTROL_RESET[BTPMA_LR_SPARE];
        end
        else if (wr_lr)
        begin
            transmit_output_disable <= MGMT_WDATA[BTPMA_LR_TX_DISABLE]; // [R11]
            high_amplitude_select <= MGMT_WDATA[BTPMA_LR_HIGH_AMP]; // [R12] [R15]
            energy_efficient_enable <= MGMT_WDATA[BTPMA_LR_EEE];
            local_pma_loopback_enable <= MGMT_WDATA[BTPMA_LR_LOOPBACK]; // [R14]
            spare_bit <= MGMT_WDATA[BTPMA_LR_SPARE];
        end
        else if (strap_pending)
            high_amplitude_select <= HIGH_AMP_STRAP; // [R12]
    end

    // bit 15 of the long-reach word self-clears one cycle after it is written
    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
            self_clear_bit <= BTPMA_LR_CONTROL_RESET[BTPMA_LR_SELF_CLEAR];
        else if (wr_lr)
            self_clear_bit <= MGMT_WDATA[BTPMA_LR_SELF_CLEAR];
        else
            self_clear_bit <= 1'b0;
    end

    // ==========================================================
    // read mux; unmapped addresses read zero, writes to the ability word fall through
    always_comb
    begin
        next_rdata = 16'h0000;
        if (sel_pma)
        begin
            case (MGMT_REG_ADDR)
                BTPMA_OFS_ABILITY:
                    next_rdata = BTPMA_ABILITY_VALUE; // [R2] [R3] [R4] [R5]
                BTPMA_OFS_CONTROL:
                begin
                    next_rdata[BTPMA_CTL_FIXED_ONE] = BTPMA_CONTROL_RESET[BTPMA_CTL_FIXED_ONE];
                    next_rdata[BTPMA_CTL_MASTER] = master_role_select;
                    next_rdata[BTPMA_CTL_TYPE_MSB:BTPMA_CTL_TYPE_LSB] = phy_type_select;
                end
                BTPMA_OFS_LR_CONTROL:
                begin
                    next_rdata[BTPMA_LR_SELF_CLEAR] = self_clear_bit;
                    next_rdata[BTPMA_LR_TX_DISABLE] = transmit_output_disable;
                    next_rdata[BTPMA_LR_HIGH_AMP] = high_amplitude_select;
                    next_rdata[BTPMA_LR_SPARE] = spare_bit;
                    next_rdata[BTPMA_LR_EEE] = energy_efficient_enable;
                    next_rdata[BTPMA_LR_LOOPBACK] = local_pma_loopback_enable;
                end
                default:
                    next_rdata = 16'h0000;
            endcase
        end
    end

    // read answer one cycle after the strobe; data holds until the next read
    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            MGMT_RDATA <= 16'h0000;
            MGMT_RVALID <= 1'b0;
        end
        else
        begin
            MGMT_RVALID <= MGMT_RD;
            if (MGMT_RD)
                MGMT_RDATA <= next_rdata;
        end
    end

    // ==========================================================
    // effective mode; negotiated values override the forced fields
    assign eff_type = (!AN_ENABLE && FORCED_LINK_EN) ? phy_type_select : AN_PHY_TYPE; // [R9]

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            MASTER_ROLE <= 1'b0;
            TYPE_MULTIDROP <= 1'b0;
            TYPE_LONG_REACH <= 1'b0;
            TYPE_FAST <= 1'b0;
            TYPE_RESERVED <= 1'b0;
            TX_OUTPUT_ENABLE <= 1'b0;
            HIGH_AMPLITUDE <= 1'b0;
            ENERGY_EFFICIENT <= 1'b0;
            PMA_LOOPBACK <= 1'b0;
        end
        else
        begin
            MASTER_ROLE <= AN_ENABLE ? AN_MASTER : master_role_select; // [R7]
            TYPE_MULTIDROP <= (eff_type == BTPMA_TYPE_MULTIDROP); // [R8]
            TYPE_LONG_REACH <= (eff_type == BTPMA_TYPE_LONG_REACH); // [R8]
            TYPE_FAST <= (eff_type == BTPMA_TYPE_FAST); // [R8]
            // 0001 is not listed either, so it is flagged with the reserved codes
            TYPE_RESERVED <= (eff_type != BTPMA_TYPE_MULTIDROP)
                && (eff_type != BTPMA_TYPE_LONG_REACH)
                && (eff_type != BTPMA_TYPE_FAST); // [R8]
            TX_OUTPUT_ENABLE <= ~transmit_output_disable; // [R11]
            HIGH_AMPLITUDE <= AN_ENABLE ? AN_HIGH_AMP : high_amplitude_select; // [R13]
            ENERGY_EFFICIENT <= energy_efficient_enable;
            PMA_LOOPBACK <= local_pma_loopback_enable; // [R14]
        end
    end

    // ==========================================================
    // checks
    chk_ability_fixed: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [R4]
        (MGMT_RD && sel_pma && MGMT_REG_ADDR == BTPMA_OFS_ABILITY)
        |=> (MGMT_RVALID && MGMT_RDATA == BTPMA_ABILITY_VALUE))
        else $error("ability word did not read 0x0004");

    chk_ability_no_write: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [R2]
        (MGMT_WR && sel_pma && MGMT_REG_ADDR == BTPMA_OFS_ABILITY ##2
         MGMT_RD && sel_pma && MGMT_REG_ADDR == BTPMA_OFS_ABILITY)
        |=> MGMT_RDATA == BTPMA_ABILITY_VALUE)
        else $error("write to ability word had an effect");

    chk_ability_low_bits: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [R3]
        (MGMT_RD && sel_pma && MGMT_REG_ADDR == BTPMA_OFS_ABILITY)
        |=> (MGMT_RDATA[BTPMA_ABL_MULTIDROP] == 1'b0
        && MGMT_RDATA[BTPMA_ABL_GIGABIT] == 1'b0 && MGMT_RDATA[BTPMA_ABL_FAST] == 1'b0))
        else $error("unsupported variant reported as supported"); // [R5]

    chk_other_device: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [R1]
        (MGMT_RD && !sel_pma) |=> (MGMT_RVALID && MGMT_RDATA == 16'h0000))
        else $error("foreign device address answered with data");

    chk_forced_master: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [R6]
        (wr_ctl && !AN_ENABLE ##1 !AN_ENABLE && !wr_ctl)
        |=> MASTER_ROLE == $past(MGMT_WDATA[BTPMA_CTL_MASTER], 2))
        else $error("forced master role not applied");

    chk_an_master: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [R7]
        AN_ENABLE |=> MASTER_ROLE == $past(AN_MASTER))
        else $error("negotiated role not followed");

    chk_type_forced: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [R9]
        (!AN_ENABLE && FORCED_LINK_EN && phy_type_select == BTPMA_TYPE_LONG_REACH)
        |=> (TYPE_LONG_REACH && !TYPE_MULTIDROP && !TYPE_FAST && !TYPE_RESERVED))
        else $error("forced long-reach type not decoded");

    chk_type_reserved: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [R8]
        (AN_ENABLE && AN_PHY_TYPE[3:2] != 2'b00) |=> (TYPE_RESERVED && !TYPE_LONG_REACH))
        else $error("reserved type code not flagged");

    chk_tx_disable: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [R11]
        (wr_lr ##1 !wr_lr) |=> TX_OUTPUT_ENABLE == !$past(MGMT_WDATA[BTPMA_LR_TX_DISABLE], 2))
        else $error("transmit output enable does not follow disable bit");

    chk_amp_select: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [R13]
        !AN_ENABLE |=> HIGH_AMPLITUDE == $past(high_amplitude_select))
        else $error("forced amplitude not applied"); // [R12]

    chk_loopback: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [R14]
        (wr_lr ##1 !wr_lr) |=> PMA_LOOPBACK == $past(MGMT_WDATA[BTPMA_LR_LOOPBACK], 2))
        else $error("loopback does not follow its bit");

    chk_keep_forced: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [R15]
        (wr_ctl && AN_ENABLE) |=> (master_role_select == $past(MGMT_WDATA[BTPMA_CTL_MASTER])
        && phy_type_select == $past(MGMT_WDATA[BTPMA_CTL_TYPE_MSB:BTPMA_CTL_TYPE_LSB])))
        else $error("forced field lost while negotiating");

endmodule

// ---- bench/btpma_host.sv ----
// host model issuing management reads and writes to the pma register bank
// assumes the device takes strobes on the rising edge and answers reads one cycle later
`timescale 1ns/1ps

module btpma_host
(
    // clock
    input wire logic clk,
    // management port toward the device
    output logic [4:0] dev,
    output logic [15:0] addr,
    output logic wr,
    output logic rd,
    output logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic rvalid
);
    // ==========================================================
    // idle bus
    initial
    begin
        dev = 5'h00;
        addr = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        wdata = 16'h0000;
    end

    // released lines show inverted data so stale values never look valid
    task automatic idle_lines();
        dev = ~dev;
        addr = ~addr;
        wdata = ~wdata;
    endtask

    // one-cycle write strobe; callers keep the type field at the long-reach code
    task automatic write(input logic [4:0] d, input logic [15:0] a, input logic [15:0] v);
        @(negedge clk);
        dev = d;
        addr = a;
        wdata = v;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        idle_lines();
    endtask

    // one-cycle read strobe, answer taken one cycle after the strobe edge
    task automatic read(input logic [4:0] d, input logic [15:0] a, output logic [15:0] v,
                        output logic ok);
        @(negedge clk);
        dev = d;
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        ok = rvalid;
        v = rdata;
        idle_lines();
    endtask
endmodule

// ---- bench/btpma_tb.sv ----
// self-checking bench for the pma/pmd control register bank
// assumes btpma_pkg and btpma_regs are compiled first
`timescale 1ns/1ps

module testbench;
    import btpma_pkg::*;

    logic REF_CLK, SYS_RST, MGMT_WR, MGMT_RD, MGMT_RVALID;
    logic [4:0] MGMT_DEV_ADDR;
    logic [15:0] MGMT_REG_ADDR, MGMT_WDATA, MGMT_RDATA;
    logic SECOND_PORT = 1'b0;
    logic HIGH_AMP_STRAP = 1'b0;
    logic AN_ENABLE = 1'b0;
    logic FORCED_LINK_EN = 1'b1;
    logic AN_MASTER = 1'b0;
    logic [3:0] AN_PHY_TYPE = 4'h0;
    logic AN_HIGH_AMP = 1'b0;
    logic MASTER_ROLE, TYPE_MULTIDROP, TYPE_LONG_REACH, TYPE_FAST, TYPE_RESERVED;
    logic TX_OUTPUT_ENABLE, HIGH_AMPLITUDE, ENERGY_EFFICIENT, PMA_LOOPBACK;
    logic [3:0] type_hot;
    int bad_count = 0;
    int checks = 0;
    logic [3:0] codes [6] = '{4'h3, 4'h2, 4'h0, 4'h8, 4'h4, 4'h1};
    logic [3:0] hots [6] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h1, 4'h1};

    // the four type outputs gathered for one compare
    assign type_hot = {TYPE_MULTIDROP, TYPE_LONG_REACH, TYPE_FAST, TYPE_RESERVED};

    // ==========================================================
    // clock and instances
    initial
    begin
        REF_CLK = 1'b0;
        forever #50 REF_CLK = ~REF_CLK;
    end

    btpma_host u_host (.clk(REF_CLK), .dev(MGMT_DEV_ADDR), .addr(MGMT_REG_ADDR), .wr(MGMT_WR),
        .rd(MGMT_RD), .wdata(MGMT_WDATA), .rdata(MGMT_RDATA), .rvalid(MGMT_RVALID));

    btpma_regs u_dut (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .MGMT_DEV_ADDR(MGMT_DEV_ADDR),
        .MGMT_REG_ADDR(MGMT_REG_ADDR), .MGMT_WR(MGMT_WR), .MGMT_RD(MGMT_RD),
        .MGMT_WDATA(MGMT_WDATA), .MGMT_RDATA(MGMT_RDATA), .MGMT_RVALID(MGMT_RVALID),
        .SECOND_PORT(SECOND_PORT), .HIGH_AMP_STRAP(HIGH_AMP_STRAP), .AN_ENABLE(AN_ENABLE),
        .FORCED_LINK_EN(FORCED_LINK_EN), .AN_MASTER(AN_MASTER), .AN_PHY_TYPE(AN_PHY_TYPE),
        .AN_HIGH_AMP(AN_HIGH_AMP), .MASTER_ROLE(MASTER_ROLE), .TYPE_MULTIDROP(TYPE_MULTIDROP),
        .TYPE_LONG_REACH(TYPE_LONG_REACH), .TYPE_FAST(TYPE_FAST), .TYPE_RESERVED(TYPE_RESERVED),
        .TX_OUTPUT_ENABLE(TX_OUTPUT_ENABLE), .HIGH_AMPLITUDE(HIGH_AMPLITUDE),
        .ENERGY_EFFICIENT(ENERGY_EFFICIENT), .PMA_LOOPBACK(PMA_LOOPBACK));

    // ==========================================================
    // comparison helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [4:0] d, input logic [15:0] a, input logic [15:0] exp);
        logic [15:0] v;
        logic ok;
        u_host.read(d, a, v, ok);
        chk((ok === 1'b1) ? v : 16'hdead, exp);
    endtask

    // mode outputs settle one edge after their cause
    task automatic step();
        @(negedge REF_CLK);
    endtask

    // ==========================================================
    // scenarios
    // port one leaves reset as master, so bit 14 joins the 0x8002 base
    task automatic t_reset();
        rd_chk(BTPMA_DEV_PMA, BTPMA_OFS_ABILITY, 16'h0004);
        rd_chk(BTPMA_DEV_PMA, BTPMA_OFS_CONTROL, 16'hc002);
        rd_chk(BTPMA_DEV_PMA, BTPMA_OFS_LR_CONTROL, 16'h0000);
        rd_chk(5'h02, BTPMA_OFS_ABILITY, 16'h0000);
        rd_chk(BTPMA_DEV_PMA, 16'h0013, 16'h0000);
        chk({15'h0, MASTER_ROLE}, 16'h0001);
        chk({15'h0, TX_OUTPUT_ENABLE}, 16'h0001);
    endtask

    task automatic t_readonly();
        u_host.write(5'h03, BTPMA_OFS_CONTROL, 16'h0002);
        u_host.write(BTPMA_DEV_PMA, BTPMA_OFS_ABILITY, 16'hffff);
        rd_chk(BTPMA_DEV_PMA, BTPMA_OFS_ABILITY, 16'h0004);
        rd_chk(BTPMA_DEV_PMA, BTPMA_OFS_CONTROL, 16'hc002);
    endtask

    task automatic t_master();
        u_host.write(BTPMA_DEV_PMA, BTPMA_OFS_CONTROL, 16'h0002);
        step();
        chk({15'h0, MASTER_ROLE}, 16'h0000);
        AN_ENABLE = 1'b1;
        AN_MASTER = 1'b1;
        step();
        chk({15'h0, MASTER_ROLE}, 16'h0001);
        u_host.write(BTPMA_DEV_PMA, BTPMA_OFS_CONTROL, 16'hc002);
        AN_MASTER = 1'b0;
        step();
        chk({15'h0, MASTER_ROLE}, 16'h0000);
        rd_chk(BTPMA_DEV_PMA, BTPMA_OFS_CONTROL, 16'hc002);
        AN_ENABLE = 1'b0;
        step();
        chk({15'h0, MASTER_ROLE}, 16'h0001);
    endtask

    task automatic t_type();
        AN_ENABLE = 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            AN_PHY_TYPE = codes[i];
            step();
            chk({12'h0, type_hot}, {12'h0, hots[i]});
        end
        AN_ENABLE = 1'b0;
        AN_PHY_TYPE = BTPMA_TYPE_FAST;
        step();
        chk({12'h0, type_hot}, 16'h0004);
        FORCED_LINK_EN = 1'b0;
        step();
        chk({12'h0, type_hot}, 16'h0002);
    endtask

    task automatic t_long_reach();
        u_host.write(BTPMA_DEV_PMA, BTPMA_OFS_LR_CONTROL, 16'h5401);
        step();
        chk({15'h0, TX_OUTPUT_ENABLE}, 16'h0000);
        chk({15'h0, HIGH_AMPLITUDE}, 16'h0001);
        chk({15'h0, ENERGY_EFFICIENT}, 16'h0001);
        chk({15'h0, PMA_LOOPBACK}, 16'h0001);
        rd_chk(BTPMA_DEV_PMA, BTPMA_OFS_LR_CONTROL, 16'h5401);
        AN_ENABLE = 1'b1;
        step();
        chk({15'h0, HIGH_AMPLITUDE}, 16'h0000);
        u_host.write(BTPMA_DEV_PMA, BTPMA_OFS_LR_CONTROL, 16'h0000);
        AN_HIGH_AMP = 1'b1;
        step();
        chk({15'h0, HIGH_AMPLITUDE}, 16'h0001);
        chk({15'h0, TX_OUTPUT_ENABLE}, 16'h0001);
        chk({15'h0, PMA_LOOPBACK}, 16'h0000);
    endtask

    // mid-run reset as the second port with the high-amplitude strap tied high
    task automatic t_straps();
        AN_ENABLE = 1'b0;
        SECOND_PORT = 1'b1;
        HIGH_AMP_STRAP = 1'b1;
        SYS_RST = 1'b1;
        repeat (3) @(negedge REF_CLK);
        SYS_RST = 1'b0;
        rd_chk(BTPMA_DEV_PMA, BTPMA_OFS_CONTROL, 16'h8002);
        rd_chk(BTPMA_DEV_PMA, BTPMA_OFS_LR_CONTROL, 16'h1000);
        chk({15'h0, MASTER_ROLE}, 16'h0000);
        chk({15'h0, HIGH_AMPLITUDE}, 16'h0001);
    endtask

    // ==========================================================
    // verdict, sequence and watchdog
    task automatic results();
        $display("checks %0d errors %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        SYS_RST = 1'b1;
        repeat (20) @(negedge REF_CLK);
        SYS_RST = 1'b0;
        t_reset();
        t_readonly();
        t_master();
        t_type();
        t_long_reach();
        t_straps();
        results();
    end

    // the tests need under a hundred cycles; 2000 leaves ample margin
    initial
    begin
        #(100 * 2000);
        bad_count++;
        results();
    end
endmodule
